// *** inc/tm0_pkg.sv ***
package tm0_pkg;
  // avalon byte address width; register byte address is four times its index
  localparam int unsigned ADDR_W = 10;
  // register indices (byte address = index * 4)
  localparam logic [7:0] CNT_IDX = 8'h01;
  localparam logic [7:0] CFG_IDX = 8'h81;
  localparam logic [7:0] STAT_IDX = 8'h02;
  // reset values
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h7B;
  // writable config bits; bit 7 is unused
  localparam logic [7:0] CFG_WMASK = 8'h7F;
  // config field positions
  localparam int unsigned IRQ_EDGE_BIT = 6;
  localparam int unsigned SRC_BIT = 5;
  localparam int unsigned EDGE_BIT = 4;
  localparam int unsigned PSA_BIT = 3;
  localparam int unsigned RATE_LSB = 0;
  localparam int unsigned RATE_W = 3;
  // status field positions
  localparam int unsigned OVF_BIT = 0;
  localparam int unsigned EXT_BIT = 1;
  // timing: instruction period in system clocks, write inhibit in periods
  localparam int unsigned INSTR_DIV = 4;
  localparam logic [1:0] INHIBIT_PERIODS = 2'h2;
  // top byte of prescale masks
  localparam logic [7:0] TMR_MASK_TOP = 8'hFF;
  localparam logic [7:0] WDT_MASK_TOP = 8'h7F;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  // bus handshake states, one-hot
  typedef enum logic [1:0] {
    TM0_BUS_IDLE = 2'b01,
    TM0_BUS_ACK = 2'b10
  } tm0_bus_t;
endpackage : tm0_pkg

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  logic clk, srst, avs_read, avs_write, avs_waitrequest, wdt_tick, wdt_clear, wdt_psc_tick;
  logic [9:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic cnt_pin, irq_pin, overflow_flag, ext_irq_flag, start, irq_level, pins_busy;
  logic [7:0] pulses, q, q0;
  int bad_count, checks_done, cycles, psc_seen, exp_cnt;
  localparam logic [9:0] CNT_A = 10'h004, CFG_A = 10'h204, ST_A = 10'h008;
  tm0_timer dut_u (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ext_count_pin(cnt_pin),
    .ext_irq_pin(irq_pin), .wdt_tick(wdt_tick), .wdt_clear(wdt_clear),
    .wdt_psc_tick(wdt_psc_tick), .overflow_flag(overflow_flag), .ext_irq_flag(ext_irq_flag));
  tm0_pins pins_u (.clk(clk), .srst(srst), .start(start), .pulses(pulses),
    .irq_level(irq_level), .ext_count_pin(cnt_pin), .ext_irq_pin(irq_pin), .busy(pins_busy));
  // 40 MHz system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cycles++;
    if (psc_seen >= 0 && wdt_psc_tick === 1'b1) psc_seen++;
    if (cycles == 60000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    @(posedge clk);
    // no local limit: the cycle ceiling ends a hang
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    q = avs_readdata[7:0];
    if (!wr) `CHK("rdata upper", 24'h00_0000, avs_readdata[31:8])
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_clk
  // count pulses on the pin and compare the gain with the model
  task automatic pin_run(input logic [7:0] cfg, input logic [7:0] n);
    bus(1'b1, CFG_A, cfg);
    bus(1'b0, CNT_A, 8'h00);
    q0 = q;
    pulses <= n;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    wait_clk(2);
    while (pins_busy === 1'b1) @(posedge clk);
    wait_clk(10);
    bus(1'b0, CNT_A, 8'h00);
    `CHK("pin count", 8'(q0 + n), q)
  endtask : pin_run
  initial begin
    {avs_read, avs_write, wdt_tick, wdt_clear, start, irq_level} = '0;
    avs_address = '0;
    avs_writedata = '0;
    avs_byteenable = 4'hF;
    pulses = 8'h00;
    srst = 1'b1;
    void'($urandom(71));
    wait_clk(6);
    srst <= 1'b0;
    @(posedge clk);
    // reset values, unmapped place, unused bit, masked byte lane
    bus(1'b0, CFG_A, 8'h00);
    `CHK("cfg reset", 8'h7B, q)
    bus(1'b0, 10'h3FC, 8'h00);
    `CHK("unmapped", 8'h00, q)
    bus(1'b1, CFG_A, 8'hFF);
    bus(1'b0, CFG_A, 8'h00);
    `CHK("cfg bit7", 8'h7F, q)
    avs_byteenable <= 4'hE;
    bus(1'b1, CNT_A, 8'h55);
    avs_byteenable <= 4'hF;
    bus(1'b0, CNT_A, 8'h00);
    `CHK("masked write", 8'h00, q)
    // write then read back at once: the inhibit keeps it still
    exp_cnt = $urandom_range(255);
    bus(1'b1, CFG_A, 8'h08);
    bus(1'b1, CNT_A, 8'(exp_cnt));
    bus(1'b0, CNT_A, 8'h00);
    `CHK("cnt write", 8'(exp_cnt), q)
    // instruction ticks, then each timer prescale ratio, by fixed read spacing
    for (int r = -1; r < 8; r++) begin
      bus(1'b1, CFG_A, (r < 0) ? 8'h08 : 8'(r));
      bus(1'b1, CNT_A, 8'($urandom_range(255)));
      wait_clk(12);
      bus(1'b0, CNT_A, 8'h00);
      q0 = q;
      wait_clk(((r < 0) ? 400 : (24 << r)) - 3);
      bus(1'b0, CNT_A, 8'h00);
      `CHK("tick gain", 8'(q0 + ((r < 0) ? 100 : 3)), q)
    end
    // rollover sets a sticky flag, write zero clears it
    bus(1'b1, CFG_A, 8'h08);
    bus(1'b1, CNT_A, 8'h00);
    bus(1'b1, ST_A, 8'h00);
    `CHK("ovf idle", 1'b0, overflow_flag)
    bus(1'b1, CNT_A, 8'hFF);
    wait_clk(20);
    `CHK("ovf flag", 1'b1, overflow_flag)
    wait_clk(40);
    bus(1'b0, ST_A, 8'h00);
    `CHK("ovf status", 1'b1, q[0])
    bus(1'b1, ST_A, 8'h00);
    bus(1'b0, ST_A, 8'h00);
    `CHK("ovf cleared", 1'b0, q[0])
    // external pin, rising then falling edge
    pin_run(8'h28, 8'h05);
    pin_run(8'h38, 8'(1 + $urandom_range(6)));
    // interrupt pin edge select, both polarities
    for (int e = 0; e < 2; e++) begin
      bus(1'b1, CFG_A, 8'(8'h08 | (e << 6)));
      bus(1'b1, ST_A, 8'h00);
      irq_level <= 1'b1;
      wait_clk(8);
      `CHK("irq rise", 1'(e), ext_irq_flag)
      irq_level <= 1'b0;
      wait_clk(8);
      `CHK("irq fall", 1'b1, ext_irq_flag)
    end
    // watchdog ratio 2^r with owner = watchdog, none when the timer owns it
    for (int r = 0; r < 9; r++) begin
      bus(1'b1, CFG_A, (r == 8) ? 8'h00 : 8'(8'h08 | r));
      wdt_clear <= 1'b1;
      @(posedge clk);
      wdt_clear <= 1'b0;
      wait_clk(2);
      psc_seen = 0;
      repeat (3 << (r % 8)) begin
        wdt_tick <= 1'b1;
        @(posedge clk);
        wdt_tick <= 1'b0;
        @(posedge clk);
      end
      wait_clk(4);
      `CHK("wdt ticks", (r == 8) ? 0 : 3, psc_seen)
    end
    // reset in mid-run brings back the reset values and drops the flags
    srst <= 1'b1;
    wait_clk(2);
    srst <= 1'b0;
    @(posedge clk);
    `CHK("ovf after reset", 1'b0, overflow_flag)
    `CHK("irq after reset", 1'b0, ext_irq_flag)
    bus(1'b0, CFG_A, 8'h00);
    `CHK("cfg after reset", 8'h7B, q)
    bus(1'b0, CNT_A, 8'h00);
    `CHK("cnt after reset", 8'h00, q)
    tally_and_finish();
  end
endmodule : tb_top

// *** sim/tm0_pins.sv ***
`timescale 1ns/1ps
// far side of the pins: a count pulse source and an interrupt line
module tm0_pins (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // control from the bench
  input wire logic start,
  input wire logic [7:0] pulses,
  input wire logic irq_level,
  // pins toward the timer
  output logic ext_count_pin,
  output logic ext_irq_pin,
  output logic busy
);
  logic [7:0] left_ff; // pulses still to send
  logic [1:0] ph_ff; // clocks spent in the current level
  // each level is held four clocks, above the three the synchroniser needs
  always_ff @(posedge clk) begin
    if (srst) begin
      left_ff <= 8'h00;
      ph_ff <= 2'h0;
      ext_count_pin <= 1'b0;
    end else if (start) begin
      left_ff <= pulses;
      ph_ff <= 2'h0;
    end else if (left_ff != 8'h00) begin
      ph_ff <= ph_ff + 2'h1;
      if (ph_ff == 2'h3) begin
        ext_count_pin <= ~ext_count_pin;
        // a pulse is finished once the pin has come back low
        if (ext_count_pin) left_ff <= left_ff - 8'h01;
      end
    end
  end
  // the interrupt line simply follows the bench, one clock late
  always_ff @(posedge clk) ext_irq_pin <= irq_level;
  assign busy = (left_ff != 8'h00);
endmodule : tm0_pins

// *** src/tm0_timer.sv ***
`timescale 1ns/1ps
// Behaviour
// [R1] count register readable and writable by software
// [R2] mode taken from written configuration register
// [R3] config bit 6 picks interrupt pin edge
// [R4] bit 5: external pin or clock/4
// [R5] bit 4: 1 falling, 0 rising count edge
// [R6] bit 3: prescaler to watchdog or timer
// [R7] bits 2-0: ratio 1:2..256 or 1:1..128
// [R8] two instruction periods inhibited after count write
// [R9] count write clears prescaler; prescaler hidden; the code clears it on count write only when the timer owns it
// [R10] rollover sets sticky flag until software clears
// [R11] config bit 7 reads zero, ignores writes
module tm0_timer #(
  parameter int unsigned INSTR_DIV = tm0_pkg::INSTR_DIV
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // avalon-mm slave
  input wire logic [tm0_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // pins, asynchronous to clk
  input wire logic ext_count_pin,
  input wire logic ext_irq_pin,
  // watchdog side of the shared prescaler
  input wire logic wdt_tick,
  input wire logic wdt_clear,
  output logic wdt_psc_tick,
  // event flags
  output logic overflow_flag,
  output logic ext_irq_flag
);

  localparam int unsigned DIV_W = (INSTR_DIV > 1) ? $clog2(INSTR_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INSTR_DIV - 1);

  // the divider needs at least two clocks per instruction period
  generate
    if (INSTR_DIV < 2) begin : g_bad_div
      $error("tm0_timer: INSTR_DIV must be at least 2");
    end
  endgenerate

  // registers
  logic [7:0] count_ff; // timer0_count
  logic [7:0] cfg_ff; // timer_option_config
  logic [7:0] psc_ff; // shared prescaler, not visible to software
  logic [1:0] inh_ff; // instruction periods still inhibited
  logic [DIV_W-1:0] div_ff; // instruction clock divider
  logic cnt_s1_ff, cnt_s2_ff, cnt_s3_ff; // count pin sync + history
  logic irq_s1_ff, irq_s2_ff, irq_s3_ff; // irq pin sync + history
  tm0_pkg::tm0_bus_t bus_ff;
  logic [31:0] rdata_ff;
  logic ovf_ff, ext_ff, wdt_tick_ff;
  logic [1:0] prime_ff; // clocks since reset, until the pin stages are full

  // configuration fields
  wire ext_irq_edge_sel = cfg_ff[tm0_pkg::IRQ_EDGE_BIT];
  wire count_source_sel = cfg_ff[tm0_pkg::SRC_BIT];
  wire count_edge_sel = cfg_ff[tm0_pkg::EDGE_BIT];
  wire prescaler_assign = cfg_ff[tm0_pkg::PSA_BIT];
  wire [2:0] prescale_rate = cfg_ff[tm0_pkg::RATE_LSB +: tm0_pkg::RATE_W];

  // bus decode; an access completes in its second cycle
  wire bus_req = avs_read | avs_write;
  wire bus_done = bus_req & (bus_ff == tm0_pkg::TM0_BUS_ACK);
  wire wr_done = avs_write & bus_done & avs_byteenable[0];
  wire hit_cnt = avs_address == {tm0_pkg::CNT_IDX, 2'b00};
  wire hit_cfg = avs_address == {tm0_pkg::CFG_IDX, 2'b00};
  wire hit_stat = avs_address == {tm0_pkg::STAT_IDX, 2'b00};
  wire cnt_wr = wr_done & hit_cnt;
  wire cfg_wr = wr_done & hit_cfg;
  wire stat_wr = wr_done & hit_stat;
  // writing zero to a status bit clears it
  // and a one leaves it, so software can never set a flag itself
  wire clr_ovf = stat_wr & ~avs_writedata[tm0_pkg::OVF_BIT];
  wire clr_ext = stat_wr & ~avs_writedata[tm0_pkg::EXT_BIT];

  // instruction period tick, clk / INSTR_DIV
  wire instr_tick = div_ff == DIV_LAST;

  // pin edges, seen only after the second sync stage
  // the stages reset low, so a pin that idles high would look like a rise;
  // edges stay masked until all three stages hold real pin samples
  wire primed = prime_ff == 2'h3;
  wire pin_rise = primed & cnt_s2_ff & ~cnt_s3_ff;
  wire pin_fall = primed & ~cnt_s2_ff & cnt_s3_ff;
  wire pin_edge = count_edge_sel ? pin_fall : pin_rise; // R5
  wire irq_rise = primed & irq_s2_ff & ~irq_s3_ff;
  wire irq_fall = primed & ~irq_s2_ff & irq_s3_ff;
  wire irq_evt = ext_irq_edge_sel ? irq_rise : irq_fall; // R3

  // count source select
  wire src_tick = count_source_sel ? pin_edge : instr_tick; // R4

  // prescaler feed and output; the mask picks the ratio
  wire psc_in = prescaler_assign ? wdt_tick : src_tick; // R6
  wire [7:0] tmr_mask = tm0_pkg::TMR_MASK_TOP >> (3'h7 - prescale_rate);
  wire [7:0] wdt_mask = tm0_pkg::WDT_MASK_TOP >> (3'h7 - prescale_rate);
  wire [7:0] psc_mask = prescaler_assign ? wdt_mask : tmr_mask; // R7
  wire psc_out = psc_in & ((psc_ff & psc_mask) == psc_mask);
  // a count write clears it only while the timer owns it
  wire psc_clr = prescaler_assign ? wdt_clear : cnt_wr; // R9

  // timer increment, bypassing the prescaler when the watchdog owns it
  wire tmr_tick = prescaler_assign ? src_tick : psc_out; // R6
  wire cnt_inc = tmr_tick & (inh_ff == 2'h0); // R8
  // a software write wins, so a write over FFh is not a rollover
  wire cnt_wrap = cnt_inc & ~cnt_wr & (count_ff == tm0_pkg::CNT_MAX); // R10

  // read mux; bit 7 of config always reads zero
  // unmapped places read zero, and the prescaler has no place at all
  wire [7:0] rd_byte = hit_cnt ? count_ff :
                       hit_cfg ? (cfg_ff & tm0_pkg::CFG_WMASK) :
                       hit_stat ? {6'h00, ext_ff, ovf_ff} : 8'h00;

  assign avs_waitrequest = bus_req & ~bus_done;
  assign avs_readdata = rdata_ff;
  assign overflow_flag = ovf_ff;
  assign ext_irq_flag = ext_ff;
  assign wdt_psc_tick = wdt_tick_ff;

  // bus handshake: one wait cycle lets read data come from a flop
  always_ff @(posedge clk) begin
    if (srst) begin
      bus_ff <= tm0_pkg::TM0_BUS_IDLE;
    end else begin
      case (bus_ff)
        tm0_pkg::TM0_BUS_IDLE: bus_ff <= bus_req ? tm0_pkg::TM0_BUS_ACK
                                                 : tm0_pkg::TM0_BUS_IDLE;
        tm0_pkg::TM0_BUS_ACK: bus_ff <= tm0_pkg::TM0_BUS_IDLE;
        default: bus_ff <= tm0_pkg::TM0_BUS_IDLE;
      endcase
    end
  end

  // read data captured in the wait cycle, held until the next read
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (avs_read & ~bus_done) begin
      rdata_ff <= {24'h00_0000, rd_byte}; // R1 R11
    end
  end

  // two-flop synchronisers plus one history stage for edges
  always_ff @(posedge clk) begin
    if (srst) begin
      {cnt_s1_ff, cnt_s2_ff, cnt_s3_ff} <= 3'h0;
      {irq_s1_ff, irq_s2_ff, irq_s3_ff} <= 3'h0;
    end else begin
      {cnt_s1_ff, cnt_s2_ff, cnt_s3_ff} <= {ext_count_pin, cnt_s1_ff, cnt_s2_ff};
      {irq_s1_ff, irq_s2_ff, irq_s3_ff} <= {ext_irq_pin, irq_s1_ff, irq_s2_ff};
    end
  end

  // priming counter; stops once the edge history is trustworthy
  always_ff @(posedge clk) begin
    if (srst) begin
      prime_ff <= 2'h0;
    end else if (!primed) begin
      prime_ff <= prime_ff + 2'h1;
    end
  end

  // instruction clock divider
  // free-running from reset; a config write does not restart its phase
  always_ff @(posedge clk) begin
    if (srst) begin
      div_ff <= '0;
    end else begin
      div_ff <= instr_tick ? '0 : div_ff + DIV_W'(1); // R4
    end
  end

  // configuration register; new fields act on the next cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_ff <= tm0_pkg::CFG_RST;
    end else if (cfg_wr) begin
      cfg_ff <= avs_writedata[7:0] & tm0_pkg::CFG_WMASK; // R2 R11
    end
  end

  // prescaler: clear beats count so a write restarts the ratio cleanly
  always_ff @(posedge clk) begin
    if (srst) begin
      psc_ff <= 8'h00;
    end else if (psc_clr) begin
      psc_ff <= 8'h00; // R9
    end else if (psc_in) begin
      psc_ff <= psc_out ? 8'h00 : psc_ff + 8'h01; // R7
    end
  end

  // write inhibit: counted in instruction periods, not system clocks
  // it runs in pin mode too, so a pin edge inside it is not counted
  always_ff @(posedge clk) begin
    if (srst) begin
      inh_ff <= 2'h0;
    end else if (cnt_wr) begin
      inh_ff <= tm0_pkg::INHIBIT_PERIODS; // R8
    end else if (instr_tick && inh_ff != 2'h0) begin
      inh_ff <= inh_ff - 2'h1; // R8
    end
  end

  // count register; a software write wins over an increment
  always_ff @(posedge clk) begin
    if (srst) begin
      count_ff <= tm0_pkg::CNT_RST;
    end else if (cnt_wr) begin
      count_ff <= avs_writedata[7:0]; // R1
    end else if (cnt_inc) begin
      count_ff <= count_ff + 8'h01;
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (srst) begin
      ovf_ff <= 1'b0;
      ext_ff <= 1'b0;
    end else begin
      ovf_ff <= cnt_wrap | (ovf_ff & ~clr_ovf); // R10
      ext_ff <= irq_evt | (ext_ff & ~clr_ext); // R3
    end
  end

  // prescaled watchdog tick, only while the watchdog owns the prescaler
  always_ff @(posedge clk) begin
    if (srst) begin
      wdt_tick_ff <= 1'b0;
    end else begin
      wdt_tick_ff <= prescaler_assign & psc_out; // R6
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // three idle cycles between instruction ticks
  sequence s_instr_gap;
    !instr_tick [*3] ##1 instr_tick;
  endsequence

  // count write followed by five cycles without increment
  sequence s_no_inc;
    !cnt_inc [*5];
  endsequence

  // one step up of the count register since the previous cycle
  sequence s_cnt_step;
    count_ff == $past(count_ff) + 8'h01;
  endsequence

  a_instr_rate: assert property (instr_tick |=> s_instr_gap) // R4
    else $error("instruction tick spacing wrong");
  a_int_source: assert property (!count_source_sel && prescaler_assign && instr_tick // R4
    && inh_ff == 2'h0 && !cnt_wr |=> s_cnt_step)
    else $error("internal tick did not count");
  a_pin_edge: assert property (count_source_sel && prescaler_assign && inh_ff == 2'h0 // R5
    && !cnt_wr && (count_edge_sel ? pin_fall : pin_rise) |=> s_cnt_step)
    else $error("selected pin edge did not count");
  a_pin_other_edge: assert property (count_source_sel && prescaler_assign && !cnt_wr // R5
    && (count_edge_sel ? pin_rise : pin_fall) |=> count_ff == $past(count_ff))
    else $error("count moved on the other pin edge");
  a_write_inhibit: assert property (cnt_wr |=> s_no_inc) // R8
    else $error("increment inside write inhibit");
  a_count_write: assert property (cnt_wr |=> count_ff == $past(avs_writedata[7:0])) // R1
    else $error("count write lost");
  a_cfg_write: assert property (cfg_wr |=>
    cfg_ff == ($past(avs_writedata[7:0]) & 8'h7F)) // R2
    else $error("config write lost");
  a_cfg_bit7: assert property (cfg_ff[7] == 1'b0) // R11
    else $error("config bit 7 set");
  a_psc_clear: assert property (cnt_wr && !prescaler_assign |=> psc_ff == 8'h00) // R9
    else $error("prescaler not cleared");
  a_ovf_set: assert property (cnt_wrap |=> ovf_ff && count_ff == 8'h00) // R10
    else $error("rollover did not set flag");
  a_ovf_hold: assert property (ovf_ff && !clr_ovf |=> ovf_ff) // R10
    else $error("overflow flag dropped");
  a_irq_flag: assert property (irq_evt |=> ext_ff) // R3
    else $error("irq edge not flagged");
  a_wdt_owner: assert property (!$past(prescaler_assign) |-> !wdt_psc_tick) // R6
    else $error("watchdog tick while timer owns");
  a_wdt_ratio: assert property (prescaler_assign && prescale_rate == 3'h0 && wdt_tick
    |=> wdt_psc_tick) // R7
    else $error("watchdog 1:1 ratio broken");

  // flags, bus and read data that software relies on
  a_ovf_clear: assert property (clr_ovf && !cnt_wrap |=> !ovf_ff) // R10
    else $error("overflow flag not cleared");
  a_write_no_ovf: assert property (cnt_wr |=> ovf_ff == $past(ovf_ff)) // R10
    else $error("count write raised overflow");
  a_rdata_upper: assert property (avs_readdata[31:8] == 24'h00_0000) // R1
    else $error("read data upper bits set");
  a_bus_wait: assert property (bus_req && bus_ff == tm0_pkg::TM0_BUS_IDLE |-> avs_waitrequest)
    else $error("first bus cycle not stalled");

endmodule : tm0_timer
